// file: rtl/irr_pkg.sv
// shared constants and types for interrupt request recognition
package irr_pkg;
    // ************************************************************
    // levels and link encodings
    // ************************************************************
    localparam int LVL_W = 3;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_NMI = 3'h7;
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_ACK = 2'h3;
    localparam logic [26:0] ACK_ADDR_HI = 27'h7ffffff;
    localparam logic [1:0] ACK_ADDR_LO = 2'h0;
    localparam logic [7:0] AUTOVEC_BASE = 8'h18;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [2:0] PSW_MASK_RESET = 3'h7;
    // ************************************************************
    // register port offsets and fields
    // ************************************************************
    localparam logic [3:0] OFS_SRC_MASK = 4'h0;
    localparam logic [3:0] OFS_AUTOVECTOR_SELECT_CFG = 4'h4;
    localparam logic [3:0] OFS_PSW_MASK = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam int AUTOVECTOR_SELECT_SHOW_BIT = 0;
    localparam logic [7:0] SRC_MASK_RESET = 8'h00;
    localparam logic [7:0] AUTOVECTOR_SELECT_CFG_RESET = 8'h00;
    // ************************************************************
    // acknowledge sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        IRR_IDLE = 2'b00,
        IRR_BUS = 2'b01,
        IRR_DONE = 2'b11
    } irr_ack_state_t;
endpackage : irr_pkg

// file: rtl/irr_if.sv
// link between the interrupt recognition device and an external requester
`timescale 1ns/1ps
`default_nettype none
interface irr_if;
    logic [2:0] encodedRequestLines; // requested level, 0 means none
    logic addressStrobe; // acknowledge cycle in progress, active high
    logic [1:0] transferType;
    logic [2:0] transferModifier;
    logic [31:0] busAddress;
    logic [7:0] vectorByte; // top data byte answered by requester
    logic transferAcknowledge; // one-cycle termination, active high

    modport dev (
        input encodedRequestLines,
        output addressStrobe,
        output transferType,
        output transferModifier,
        output busAddress,
        input vectorByte,
        input transferAcknowledge
    );
    modport per (
        output encodedRequestLines,
        input addressStrobe,
        input transferType,
        input transferModifier,
        input busAddress,
        output vectorByte,
        output transferAcknowledge
    );
endinterface : irr_if
`default_nettype wire

// file: rtl/irr_requester.sv
// external peripheral end: drives a request level and answers acknowledge reads
`timescale 1ns/1ps
`default_nettype none
module irr_requester (
    input wire logic sys_clk,
    input wire logic reset,
    irr_if.per link,
    input wire logic reqStrobe,
    input wire logic [2:0] reqLevelIn,
    input wire logic [7:0] reqVector,
    input wire logic dropStrobe,
    input wire logic forceClear,
    output logic [2:0] heldLevel,
    output logic ackSeen
);
    logic [2:0] level_q, level_d;
    logic [7:0] vec_q, vec_d;
    logic seen_q, seen_d;
    logic dropPend_q, dropPend_d;
    logic ta_q, ta_d;
    logic [7:0] data_q, data_d;
    logic ackMatch;

    // ************************************************************
    // request hold and acknowledge answer
    // ************************************************************
    assign ackMatch = link.addressStrobe && (link.transferType == irr_pkg::TT_ACK)
        && (link.transferModifier == level_q) && (level_q != irr_pkg::LVL_NONE);

    // next level, hold-until-acknowledge and reply
    always_comb begin
        level_d = level_q;
        vec_d = vec_q;
        seen_d = seen_q | ackMatch; // ack cycle began for our level
        dropPend_d = dropPend_q | dropStrobe;
        ta_d = ackMatch && !ta_q;
        data_d = ackMatch ? vec_q : irr_pkg::VEC_NONE; // [RULE18]
        if (forceClear) begin
            level_d = irr_pkg::LVL_NONE; // handler cleared source with no ack cycle
            dropPend_d = 1'b0;
        end else if (reqStrobe) begin
            level_d = reqLevelIn;
            vec_d = reqVector;
            seen_d = 1'b0;
            dropPend_d = 1'b0;
        end else if (seen_d && dropPend_d) begin
            level_d = irr_pkg::LVL_NONE; // drop only after ack began [RULE4] [RULE12] [RULE15]
            dropPend_d = 1'b0;
        end
    end

    // registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            level_q <= irr_pkg::LVL_NONE;
            vec_q <= irr_pkg::VEC_NONE;
            seen_q <= 1'b0;
            dropPend_q <= 1'b0;
            ta_q <= 1'b0;
            data_q <= irr_pkg::VEC_NONE;
        end else begin
            level_q <= level_d;
            vec_q <= vec_d;
            seen_q <= seen_d;
            dropPend_q <= dropPend_d;
            ta_q <= ta_d;
            data_q <= data_d;
        end
    end

    assign link.encodedRequestLines = level_q;
    assign link.vectorByte = data_q;
    assign link.transferAcknowledge = ta_q;
    assign heldLevel = level_q;
    assign ackSeen = seen_q;
endmodule : irr_requester
`default_nettype wire

// file: rtl/irr_device.sv
// device end: request qualification, masking, exception take and acknowledge cycle
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RULE1) take only level above status mask
// (RULE2) source mask blocks sources before core
// (RULE3) request valid after two stable clocks
// (RULE4) requester holds level until acknowledge begins
// (RULE5) levels 1-7 level-sensitive, 7 also edge
// (RULE6) take at boundary after higher exceptions
// (RULE7) one handler instruction before next take
// (RULE8) internal autovector: no external acknowledge cycle
// (RULE9) external autovector: strobe only if show flag 0
// (RULE10) level 7 nonmaskable, upward transition triggers
// (RULE11) held level 7 gives one interrupt
// (RULE12) second edge: hold, drop, raise again
// (RULE13) lowered mask retakes held level 7
// (RULE14) on return, mask back to 7
// (RULE15) hold level 7 until second acknowledge
// (RULE16) software raises mask before masking sources
// (RULE17) acknowledge read type, modifier, address layout
// (RULE18) requester answers vector on top byte
// (RULE19) zero means no request, else level
// (RULE20) edge flag on change below 7 to 7
module irr_device (
    input wire logic sys_clk,
    input wire logic reset,
    irr_if.dev link,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic instrBoundary,
    input wire logic higherExcPending,
    input wire logic handlerDone,
    input wire logic [2:0] restoreMask,
    input wire logic [2:0] intLevel,
    input wire logic intAutovector,
    output logic excTake,
    output logic [2:0] excLevel,
    output logic vectorValid,
    output logic [7:0] vectorNum
);
    // ************************************************************
    // request qualification
    // ************************************************************
    logic [2:0] sync1_q, sync2_q, sync3_q, qual_q, prevQual_q, qual_d;
    logic nmiPend_q, nmiPend_d, nmiEdge;

    // hold the last level seen stable for two clocks
    always_comb begin
        qual_d = (sync2_q == sync3_q) ? sync3_q : qual_q; // [RULE3]
        nmiEdge = (prevQual_q != irr_pkg::LVL_NMI) && (qual_q == irr_pkg::LVL_NMI); // [RULE20]
    end

    // sample pipeline and qualified level
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= irr_pkg::LVL_NONE;
            sync2_q <= irr_pkg::LVL_NONE;
            sync3_q <= irr_pkg::LVL_NONE;
            qual_q <= irr_pkg::LVL_NONE;
            prevQual_q <= irr_pkg::LVL_NONE;
        end else begin
            sync1_q <= link.encodedRequestLines; // [RULE3]
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            qual_q <= qual_d;
            prevQual_q <= qual_q;
        end
    end

    // ************************************************************
    // masking and take decision
    // ************************************************************
    logic [7:0] srcMask_q, srcMask_d, avCfg_q, avCfg_d;
    logic [2:0] pswMask_q, pswMask_d;
    logic block_q, block_d;
    logic [2:0] extFwd, cand;
    logic candInt, canTake, takeNmi, takeLvl, take;
    logic [2:0] takeLevel;
    irr_pkg::irr_ack_state_t state_q, state_d;

    // forwarded level: zero is no request, level 7 ignores the source mask
    always_comb begin
        extFwd = irr_pkg::LVL_NONE; // [RULE19]
        if (qual_q == irr_pkg::LVL_NMI || (qual_q != irr_pkg::LVL_NONE && !srcMask_q[qual_q])) begin
            extFwd = qual_q; // [RULE2] [RULE10]
        end
        candInt = intLevel > extFwd;
        cand = candInt ? intLevel : extFwd;
        canTake = instrBoundary && !higherExcPending && !block_q
            && (state_q == irr_pkg::IRR_IDLE); // [RULE6] [RULE7]
        takeNmi = canTake && nmiPend_q; // [RULE10] [RULE11]
        takeLvl = canTake && !nmiPend_q && (cand > pswMask_q); // [RULE1] [RULE5] [RULE13]
        take = takeNmi || takeLvl;
        takeLevel = takeNmi ? irr_pkg::LVL_NMI : cand;
    end

    // next mask, pending edge, block and configuration
    always_comb begin
        nmiPend_d = nmiEdge | (nmiPend_q & ~takeNmi); // new edge wins over the take [RULE5]
        block_d = block_q;
        if (take) begin
            block_d = 1'b1; // [RULE7]
        end else if (instrBoundary) begin
            block_d = 1'b0; // first handler instruction has completed
        end
        srcMask_d = srcMask_q;
        avCfg_d = avCfg_q;
        pswMask_d = pswMask_q;
        if (regWr && regAddr == irr_pkg::OFS_SRC_MASK) begin
            srcMask_d = regWrData[7:0];
        end
        if (regWr && regAddr == irr_pkg::OFS_AUTOVECTOR_SELECT_CFG) begin
            avCfg_d = regWrData[7:0];
        end
        if (regWr && regAddr == irr_pkg::OFS_PSW_MASK) begin
            pswMask_d = regWrData[2:0];
        end
        if (take) begin
            pswMask_d = takeLevel;
        end else if (handlerDone) begin
            pswMask_d = restoreMask;
            if (qual_q == irr_pkg::LVL_NMI && restoreMask < irr_pkg::LVL_NMI) begin
                pswMask_d = irr_pkg::LVL_NMI; // [RULE14]
            end
        end
    end

    // mask and control registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nmiPend_q <= 1'b0;
            block_q <= 1'b0;
            srcMask_q <= irr_pkg::SRC_MASK_RESET;
            avCfg_q <= irr_pkg::AUTOVECTOR_SELECT_CFG_RESET;
            pswMask_q <= irr_pkg::PSW_MASK_RESET;
        end else begin
            nmiPend_q <= nmiPend_d;
            block_q <= block_d;
            srcMask_q <= srcMask_d;
            avCfg_q <= avCfg_d;
            pswMask_q <= pswMask_d;
        end
    end

    // ************************************************************
    // acknowledge sequencer
    // ************************************************************
    logic [2:0] lvl_q, lvl_d, tm_q, tm_d;
    logic [1:0] tt_q, tt_d;
    logic [31:0] addr_q, addr_d;
    logic autovector_select_q, autovector_select_d, as_q, as_d, take_q, valid_q, valid_d;
    logic [7:0] vec_q, vec_d;

    // choose autovector or bus acknowledge, then deliver the vector
    always_comb begin
        state_d = state_q;
        lvl_d = lvl_q;
        autovector_select_d = autovector_select_q;
        vec_d = vec_q;
        valid_d = 1'b0;
        case (state_q)
            irr_pkg::IRR_IDLE: begin
                if (take) begin
                    lvl_d = takeLevel;
                    vec_d = 8'(irr_pkg::AUTOVEC_BASE + {5'h00, takeLevel});
                    if (takeLvl && candInt && intAutovector) begin
                        autovector_select_d = 1'b1;
                        state_d = irr_pkg::IRR_DONE; // [RULE8]
                    end else if (avCfg_q[takeLevel]) begin
                        autovector_select_d = 1'b1;
                        state_d = avCfg_q[irr_pkg::AUTOVECTOR_SELECT_SHOW_BIT] ? irr_pkg::IRR_DONE
                            : irr_pkg::IRR_BUS; // [RULE9]
                    end else begin
                        autovector_select_d = 1'b0;
                        state_d = irr_pkg::IRR_BUS;
                    end
                end
            end
            irr_pkg::IRR_BUS: begin
                if (link.transferAcknowledge) begin
                    if (!autovector_select_q) begin
                        vec_d = link.vectorByte; // [RULE18]
                    end
                    state_d = irr_pkg::IRR_DONE;
                end
            end
            irr_pkg::IRR_DONE: begin
                valid_d = 1'b1;
                state_d = irr_pkg::IRR_IDLE;
            end
            default: begin
                state_d = irr_pkg::IRR_IDLE;
            end
        endcase
        as_d = (state_d == irr_pkg::IRR_BUS); // [RULE9]
        tt_d = as_d ? irr_pkg::TT_ACK : irr_pkg::TT_NORMAL; // [RULE17]
        tm_d = as_d ? lvl_d : irr_pkg::LVL_NONE; // [RULE17]
        addr_d = as_d ? {irr_pkg::ACK_ADDR_HI, lvl_d, irr_pkg::ACK_ADDR_LO} : 32'h00000000;
    end

    // sequencer registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= irr_pkg::IRR_IDLE;
            lvl_q <= irr_pkg::LVL_NONE;
            autovector_select_q <= 1'b0;
            vec_q <= irr_pkg::VEC_NONE;
            as_q <= 1'b0;
            tt_q <= irr_pkg::TT_NORMAL;
            tm_q <= irr_pkg::LVL_NONE;
            addr_q <= 32'h00000000;
            take_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lvl_q <= lvl_d;
            autovector_select_q <= autovector_select_d;
            vec_q <= vec_d;
            as_q <= as_d;
            tt_q <= tt_d;
            tm_q <= tm_d;
            addr_q <= addr_d;
            take_q <= take;
            valid_q <= valid_d;
        end
    end

    // acknowledge read fields leave straight from their registers
    assign link.addressStrobe = as_q;
    assign link.transferType = tt_q;
    assign link.transferModifier = tm_q;
    assign link.busAddress = addr_q;
    assign excTake = take_q;
    assign excLevel = lvl_q;
    assign vectorValid = valid_q;
    assign vectorNum = vec_q;

    // ************************************************************
    // register read port
    // ************************************************************
    logic [31:0] rd_q, rd_d;

    // read data stands in the cycle after the read strobe only
    always_comb begin
        rd_d = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                irr_pkg::OFS_SRC_MASK: rd_d = {24'h000000, srcMask_q};
                irr_pkg::OFS_AUTOVECTOR_SELECT_CFG: rd_d = {24'h000000, avCfg_q};
                irr_pkg::OFS_PSW_MASK: rd_d = {29'h00000000, pswMask_q};
                irr_pkg::OFS_STATUS: rd_d = {16'h0000, vec_q, state_q, nmiPend_q, block_q,
                    1'b0, qual_q};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_q <= 32'h00000000;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign regRdData = rd_q;
endmodule : irr_device
`default_nettype wire

// file: verif/irr_link_props.sv
// concurrent checks on the request and acknowledge link
`timescale 1ns/1ps
`default_nettype none
module irr_link_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [2:0] encodedRequestLines,
    input wire logic addressStrobe,
    input wire logic [1:0] transferType,
    input wire logic [2:0] transferModifier,
    input wire logic [31:0] busAddress,
    input wire logic [7:0] vectorByte,
    input wire logic transferAcknowledge
);
    // ****************************************
    // acknowledge cycle shape on the link
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ack_type: assert property (addressStrobe |-> transferType == irr_pkg::TT_ACK)
        else $error("acknowledge cycle with wrong type");
    a_ack_address: assert property (addressStrobe |-> busAddress ==
        {irr_pkg::ACK_ADDR_HI, transferModifier, irr_pkg::ACK_ADDR_LO})
        else $error("acknowledge address layout wrong");
    a_idle_bus: assert property (!addressStrobe |-> transferType == 2'h0
        && transferModifier == 3'h0 && busAddress == 32'h0)
        else $error("bus fields active without strobe");
    a_level_nonzero: assert property ($rose(addressStrobe) |-> transferModifier != 3'h0)
        else $error("acknowledge for level zero");
    a_modifier_held: assert property (addressStrobe && $past(addressStrobe) |->
        $stable(transferModifier))
        else $error("modifier changed inside acknowledge");
    a_ack_answered: assert property ($rose(addressStrobe) |-> ##1 transferAcknowledge)
        else $error("acknowledge not terminated in time");
    a_ta_in_cycle: assert property (transferAcknowledge |-> addressStrobe)
        else $error("termination outside acknowledge");
    a_strobe_ends: assert property (transferAcknowledge |=>
        !addressStrobe && !transferAcknowledge)
        else $error("strobe not released after termination");
endmodule : irr_link_props
`default_nettype wire

// file: verif/interrupt_request_recognition_tb_top.sv
// bench for the recognition device facing the requester
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_recognition_tb_top;
    // ****************************************
    // signals and instances
    // ****************************************
    logic sys_clk, reset, regWr, regRd, instrBoundary, higherExcPending, handlerDone;
    logic intAutovector, excTake, vectorValid, reqStrobe, dropStrobe, forceClear, ackSeen;
    logic prevAs;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic [2:0] restoreMask, intLevel, reqLevelIn, excLevel, heldLevel, lvlSeen, l, m;
    logic [7:0] reqVector, vectorNum, vecSeen, v;
    int n_errors = 0, tests_run = 0, nTake = 0, nBus = 0, seed = 32'h35bb, i;
    irr_if link ();
    irr_device i_irr_device (.sys_clk(sys_clk), .reset(reset), .link(link),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .instrBoundary(instrBoundary),
        .higherExcPending(higherExcPending), .handlerDone(handlerDone),
        .restoreMask(restoreMask), .intLevel(intLevel), .intAutovector(intAutovector),
        .excTake(excTake), .excLevel(excLevel), .vectorValid(vectorValid),
        .vectorNum(vectorNum));
    irr_requester i_irr_requester (.sys_clk(sys_clk), .reset(reset), .link(link),
        .reqStrobe(reqStrobe), .reqLevelIn(reqLevelIn), .reqVector(reqVector),
        .dropStrobe(dropStrobe), .forceClear(forceClear), .heldLevel(heldLevel),
        .ackSeen(ackSeen));
    irr_link_props i_irr_link_props (.sys_clk(sys_clk), .reset(reset),
        .encodedRequestLines(link.encodedRequestLines), .addressStrobe(link.addressStrobe),
        .transferType(link.transferType), .transferModifier(link.transferModifier),
        .busAddress(link.busAddress), .vectorByte(link.vectorByte),
        .transferAcknowledge(link.transferAcknowledge));
    // clock source
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // counts takes and shown acknowledge cycles, records the last delivered vector
    always @(negedge sys_clk) begin
        if (excTake === 1'b1) begin
            nTake++;
            lvlSeen = excLevel;
        end
        if (vectorValid === 1'b1) vecSeen = vectorNum;
        if (link.addressStrobe === 1'b1 && prevAs !== 1'b1) nBus++;
        prevAs = link.addressStrobe;
    end
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [7:0] av(input logic [2:0] lv);
        return 8'(irr_pkg::AUTOVEC_BASE + {5'h0, lv});
    endfunction : av
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input logic [3:0] p, input logic [2:0] r);
        @(posedge sys_clk);
        {forceClear, dropStrobe, handlerDone, instrBoundary} <= p;
        restoreMask <= r;
        @(posedge sys_clk);
        {forceClear, dropStrobe, handlerDone, instrBoundary} <= 4'h0;
    endtask : step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= {24'h0, d};
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        chk(regRdData, {24'h0, e});
    endtask : rd
    // loads a level, optionally clearing it again after one cycle
    task automatic req(input logic [2:0] lv, input logic [7:0] vec, input logic glitch);
        @(posedge sys_clk);
        reqLevelIn <= lv;
        reqVector <= vec;
        reqStrobe <= 1'b1;
        @(posedge sys_clk);
        reqStrobe <= 1'b0;
        forceClear <= glitch;
        @(posedge sys_clk);
        forceClear <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : req
    // one boundary; on a take, handler return and a boundary that must not take
    task automatic take(input logic t, input logic [2:0] lv, input logic [7:0] vec,
                        input logic bus, input logic [2:0] r);
        int k0;
        int b0;
        k0 = nTake;
        b0 = nBus;
        vecSeen = ~vec;
        step(4'h1, r);
        repeat (8) @(posedge sys_clk);
        chk(32'(nTake - k0), {31'h0, t});
        chk(32'(nBus - b0), {31'h0, bus});
        if (t) begin
            chk({29'h0, lvlSeen}, {29'h0, lv});
            chk({24'h0, vecSeen}, {24'h0, vec});
            rd(irr_pkg::OFS_PSW_MASK, {5'h0, lv});
            step(4'h2, r);
            step(4'h1, r);
            repeat (4) @(posedge sys_clk);
            chk(32'(nTake - k0), 32'h1);
        end
    endtask : take
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        #4000000;
        n_errors++;
        give_verdict();
    end
    initial begin
        {reset, regWr, regRd, instrBoundary, higherExcPending, handlerDone} = 6'h20;
        {reqStrobe, dropStrobe, forceClear, intAutovector} = 4'h0;
        {restoreMask, intLevel, reqLevelIn, regAddr} = 13'h0;
        regWrData = 32'h0;
        reqVector = 8'h0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(irr_pkg::OFS_PSW_MASK, 8'h07);
        rd(irr_pkg::OFS_SRC_MASK, 8'h00);
        rd(irr_pkg::OFS_AUTOVECTOR_SELECT_CFG, 8'h00);
        rd(4'h2, 8'h00);
        rd(irr_pkg::OFS_STATUS, 8'h00);
        wr(irr_pkg::OFS_PSW_MASK, 8'h03);
        v = 8'($random(seed));
        req(3'h3, v, 1'b0);
        rd(irr_pkg::OFS_STATUS, 8'h03);
        take(1'b0, 3'h3, v, 1'b0, 3'h0);
        wr(irr_pkg::OFS_PSW_MASK, 8'h02);
        higherExcPending <= 1'b1;
        take(1'b0, 3'h3, v, 1'b0, 3'h0);
        higherExcPending <= 1'b0;
        take(1'b1, 3'h3, v, 1'b1, 3'h0);
        wr(irr_pkg::OFS_PSW_MASK, 8'h04);
        wr(irr_pkg::OFS_SRC_MASK, 8'h08);
        wr(irr_pkg::OFS_PSW_MASK, 8'h00);
        take(1'b0, 3'h3, v, 1'b0, 3'h0);
        wr(irr_pkg::OFS_SRC_MASK, 8'h00);
        take(1'b1, 3'h3, v, 1'b1, 3'h0);
        req(3'h5, v, 1'b1);
        take(1'b0, 3'h5, v, 1'b0, 3'h0);
        intLevel <= 3'h5;
        intAutovector <= 1'b1;
        take(1'b1, 3'h5, av(3'h5), 1'b0, 3'h0);
        intLevel <= 3'h0;
        for (i = 0; i < 2; i++) begin
            wr(irr_pkg::OFS_AUTOVECTOR_SELECT_CFG, 8'h04 | {7'h0, ~i[0]});
            req(3'h2, v, 1'b0);
            take(1'b1, 3'h2, av(3'h2), i[0], 3'h0);
            chk({31'h0, ackSeen}, {31'h0, i[0]});
            step(4'h8, 3'h0);
        end
        wr(irr_pkg::OFS_AUTOVECTOR_SELECT_CFG, 8'h00);
        wr(irr_pkg::OFS_SRC_MASK, 8'h80);
        wr(irr_pkg::OFS_PSW_MASK, 8'h07);
        req(3'h7, v, 1'b0);
        take(1'b1, 3'h7, v, 1'b1, 3'h3);
        rd(irr_pkg::OFS_PSW_MASK, 8'h07);
        take(1'b0, 3'h7, v, 1'b0, 3'h7);
        wr(irr_pkg::OFS_PSW_MASK, 8'h03);
        take(1'b1, 3'h7, v, 1'b1, 3'h7);
        chk({31'h0, ackSeen}, 32'h1);
        step(4'h4, 3'h7);
        repeat (5) @(posedge sys_clk);
        chk({29'h0, heldLevel}, 32'h0);
        req(3'h7, v, 1'b0);
        take(1'b1, 3'h7, v, 1'b1, 3'h7);
        req(3'h0, v, 1'b0);
        wr(irr_pkg::OFS_SRC_MASK, 8'h00);
        for (i = 0; i < 8; i++) begin
            l = 3'((($random(seed) & 32'h7fffffff) % 6) + 1);
            m = 3'($random(seed));
            v = 8'($random(seed));
            wr(irr_pkg::OFS_PSW_MASK, {5'h0, m});
            req(l, v, 1'b0);
            take(l > m, l, v, l > m, 3'h0);
            req(3'h0, v, 1'b0);
        end
        give_verdict();
    end
endmodule : interrupt_request_recognition_tb_top
`default_nettype wire
